/* logic/line_cfg_regs.sv */
/*
 Configuration and status registers of a four-channel line unit,
 reached over AXI4-Lite, with per-channel control outputs.
 Assumes inputs synchronous to SYS_CLK and a software master that
 issues one write and one read at a time.
*/
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module line_cfg_regs #(
   parameter int unsigned CHANNELS = line_cfg_pkg::NUM_CH
) (
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic CLK_EN,
   // axi4-lite slave
   input wire logic [line_cfg_pkg::ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic [2:0] S_AXI_AWPROT,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [line_cfg_pkg::DATA_W-1:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [line_cfg_pkg::ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic [2:0] S_AXI_ARPROT,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [line_cfg_pkg::DATA_W-1:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // channel pins and status
   input wire logic [CHANNELS-1:0] ALARM_STATUS,
   input wire logic [CHANNELS-1:0] TX_NEGATIVE_RAIL_PIN,
   input wire logic [CHANNELS-1:0] TX_LINE_CLOCK_PIN,
   // per-channel controls and expanded bank flag
   output logic [CHANNELS-1:0] SINGLE_RAIL_MODE,
   output logic [CHANNELS-1:0] AMI_SELECT,
   output logic [CHANNELS-1:0] CLK_RECOVERY_ON,
   output logic [CHANNELS-1:0] RX_POWERDOWN,
   output logic [CHANNELS-1:0] TX_POWERDOWN,
   output logic [CHANNELS-1:0] TX_HIGH_Z,
   output logic [CHANNELS-1:0] ZERO_RUN_DETECT_ON,
   output logic [CHANNELS-1:0] VIOLATION_DETECT_ON,
   output logic [CHANNELS-1:0] RX_EQUALIZER_ON,
   output logic EXPANDED_BANK
);

   // channel fields live in byte lane 0 of each register
   if (CHANNELS < 1 || CHANNELS > 8) begin : g_bad_channels
      $error("CHANNELS must be 1 to 8");
   end

   localparam int unsigned CW = CHANNELS;

   /*****************************************************************
    state
   *****************************************************************/
   typedef struct packed {
      logic aw_held;
      logic [line_cfg_pkg::ADDR_W-1:0] aw_addr;
      logic w_held;
      logic [line_cfg_pkg::DATA_W-1:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [line_cfg_pkg::DATA_W-1:0] rdata;
      logic [7:0] bank_ptr;
      logic [CW-1:0] single_rail;
      logic [CW-1:0] line_code;
      logic [CW-1:0] clk_bypass;
      logic [CW-1:0] rx_pdn;
      logic [CW-1:0] tx_pdn;
      logic [CW-1:0] zero_run;
      logic [CW-1:0] viol_dis;
      logic [CW-1:0] equalizer;
      logic [CW-1:0] alarm_mask;
      logic [CW-1:0] alarm_flags;
      logic [CW-1:0] alarm_last;
   } state_s;

   state_s state_reg;
   state_s state_next;

   typedef enum {
      SEL_NONE,
      SEL_SINGLE_RAIL,
      SEL_LINE_CODE,
      SEL_CLK_BYPASS,
      SEL_RX_PDN,
      SEL_TX_PDN,
      SEL_ZERO_RUN,
      SEL_VIOL_DIS,
      SEL_EQUALIZER,
      SEL_ALARM_MASK,
      SEL_ALARM_FLAGS,
      SEL_BANK_PTR
   } reg_sel_e;

   /*****************************************************************
    address decode
   *****************************************************************/
   function automatic reg_sel_e decode(
      input logic [line_cfg_pkg::ADDR_W-1:0] addr,
      input logic [7:0] bank
   );
      logic [7:0] ofs;
      reg_sel_e sel;
      ofs = {line_cfg_pkg::WORD_LSB'(0),
         addr[line_cfg_pkg::ADDR_W-1:line_cfg_pkg::WORD_LSB]};
      sel = SEL_NONE;
      if (addr[line_cfg_pkg::WORD_LSB-1:0] != '0) begin
         sel = SEL_NONE;
      end else if (ofs == line_cfg_pkg::OFS_BANK_PTR) begin
         sel = SEL_BANK_PTR;
      end else if (bank == line_cfg_pkg::BANK_EXPANDED) begin
         case (ofs)
            line_cfg_pkg::OFS_SINGLE_RAIL: sel = SEL_SINGLE_RAIL;
            line_cfg_pkg::OFS_LINE_CODE: sel = SEL_LINE_CODE;
            line_cfg_pkg::OFS_CLK_BYPASS: sel = SEL_CLK_BYPASS;
            line_cfg_pkg::OFS_RX_PDN: sel = SEL_RX_PDN;
            line_cfg_pkg::OFS_TX_PDN: sel = SEL_TX_PDN;
            line_cfg_pkg::OFS_ZERO_RUN: sel = SEL_ZERO_RUN;
            line_cfg_pkg::OFS_VIOL_DIS: sel = SEL_VIOL_DIS;
            line_cfg_pkg::OFS_EQUALIZER: sel = SEL_EQUALIZER;
            default: sel = SEL_NONE;
         endcase
      end else if (bank == line_cfg_pkg::BANK_PRIMARY) begin
         case (ofs)
            line_cfg_pkg::OFS_ALARM_MASK: sel = SEL_ALARM_MASK;
            line_cfg_pkg::OFS_ALARM_FLAGS: sel = SEL_ALARM_FLAGS;
            default: sel = SEL_NONE;
         endcase
      end else begin
         sel = SEL_NONE;
      end
      return sel;
   endfunction

   // byte-lane 0 merge of a channel field; upper bits are dropped
   function automatic logic [CW-1:0] merge(
      input logic [CW-1:0] old,
      input logic [line_cfg_pkg::DATA_W-1:0] data,
      input logic [3:0] strb
   );
      logic [CW-1:0] res;
      res = strb[0] ? data[CW-1:0] : old;
      return res;
   endfunction

   /*****************************************************************
    next state
   *****************************************************************/
   logic aw_now;
   logic w_now;
   logic do_write;
   logic do_read;
   logic [line_cfg_pkg::ADDR_W-1:0] wr_addr;
   logic [line_cfg_pkg::DATA_W-1:0] wr_data;
   logic [3:0] wr_strb;
   reg_sel_e wsel;
   reg_sel_e rsel;
   logic [CW-1:0] alarm_event;
   logic flags_read;
   logic [CW-1:0] rfield;

   always_comb begin
      state_next = state_reg;
      rfield = '0;
      aw_now = S_AXI_AWVALID && !state_reg.aw_held && !state_reg.bvalid;
      w_now = S_AXI_WVALID && !state_reg.w_held && !state_reg.bvalid;
      wr_addr = state_reg.aw_held ? state_reg.aw_addr : S_AXI_AWADDR;
      wr_data = state_reg.w_held ? state_reg.w_data : S_AXI_WDATA;
      wr_strb = state_reg.w_held ? state_reg.w_strb : S_AXI_WSTRB;
      do_write = (state_reg.aw_held || aw_now) &&
         (state_reg.w_held || w_now) && !state_reg.bvalid;
      do_read = S_AXI_ARVALID && !state_reg.rvalid;
      wsel = decode(wr_addr, state_reg.bank_ptr);
      rsel = decode(S_AXI_ARADDR, state_reg.bank_ptr);
      flags_read = do_read && (rsel == SEL_ALARM_FLAGS);

      // alarm change detection
      alarm_event = (ALARM_STATUS ^ state_reg.alarm_last) &
         state_reg.alarm_mask;
      state_next.alarm_last = ALARM_STATUS;
      state_next.alarm_flags = (flags_read ? '0 : state_reg.alarm_flags)
         | alarm_event;

      // write channel
      if (aw_now && !do_write) begin
         state_next.aw_held = 1'b1;
         state_next.aw_addr = S_AXI_AWADDR;
      end
      if (w_now && !do_write) begin
         state_next.w_held = 1'b1;
         state_next.w_data = S_AXI_WDATA;
         state_next.w_strb = S_AXI_WSTRB;
      end
      if (do_write) begin
         state_next.aw_held = 1'b0;
         state_next.w_held = 1'b0;
         state_next.bvalid = 1'b1;
         state_next.bresp = line_cfg_pkg::RESP_OKAY;
         case (wsel)
            SEL_SINGLE_RAIL: state_next.single_rail =
               merge(state_reg.single_rail, wr_data, wr_strb);
            SEL_LINE_CODE: state_next.line_code =
               merge(state_reg.line_code, wr_data, wr_strb);
            SEL_CLK_BYPASS: state_next.clk_bypass =
               merge(state_reg.clk_bypass, wr_data, wr_strb);
            SEL_RX_PDN: state_next.rx_pdn =
               merge(state_reg.rx_pdn, wr_data, wr_strb);
            SEL_TX_PDN: state_next.tx_pdn =
               merge(state_reg.tx_pdn, wr_data, wr_strb);
            SEL_ZERO_RUN: state_next.zero_run =
               merge(state_reg.zero_run, wr_data, wr_strb);
            SEL_VIOL_DIS: state_next.viol_dis =
               merge(state_reg.viol_dis, wr_data, wr_strb);
            SEL_EQUALIZER: state_next.equalizer =
               merge(state_reg.equalizer, wr_data, wr_strb);
            SEL_ALARM_MASK: state_next.alarm_mask =
               merge(state_reg.alarm_mask, wr_data, wr_strb);
            SEL_BANK_PTR: begin
               if (wr_strb[0]) begin
                  state_next.bank_ptr = wr_data[7:0];
               end
            end
            // read-only flags ignore writes
            SEL_ALARM_FLAGS: state_next.bresp = line_cfg_pkg::RESP_OKAY;
            default: state_next.bresp = line_cfg_pkg::RESP_SLVERR;
         endcase
      end
      if (state_reg.bvalid && S_AXI_BREADY) begin
         state_next.bvalid = 1'b0;
      end

      // read channel
      if (do_read) begin
         state_next.rvalid = 1'b1;
         state_next.rresp = line_cfg_pkg::RESP_OKAY;
         case (rsel)
            SEL_SINGLE_RAIL: rfield = state_reg.single_rail;
            SEL_LINE_CODE: rfield = state_reg.line_code;
            SEL_CLK_BYPASS: rfield = state_reg.clk_bypass;
            SEL_RX_PDN: rfield = state_reg.rx_pdn;
            SEL_TX_PDN: rfield = state_reg.tx_pdn;
            SEL_ZERO_RUN: rfield = state_reg.zero_run;
            SEL_VIOL_DIS: rfield = state_reg.viol_dis;
            SEL_EQUALIZER: rfield = state_reg.equalizer;
            SEL_ALARM_MASK: rfield = state_reg.alarm_mask;
            SEL_ALARM_FLAGS: rfield = state_reg.alarm_flags;
            SEL_BANK_PTR: rfield = '0;
            default: begin
               rfield = '0;
               state_next.rresp = line_cfg_pkg::RESP_SLVERR;
            end
         endcase
         if (rsel == SEL_BANK_PTR) begin
            state_next.rdata = {24'h000000, state_reg.bank_ptr};
         end else begin
            state_next.rdata = '0;
            state_next.rdata[CW-1:0] = rfield;
         end
      end else if (state_reg.rvalid && S_AXI_RREADY) begin
         state_next.rvalid = 1'b0;
      end
   end

   /*****************************************************************
    registers
   *****************************************************************/
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         state_reg <= '0;
         state_reg.bank_ptr <= line_cfg_pkg::BANK_PTR_RST;
         state_reg.alarm_flags <= CW'(line_cfg_pkg::CH_RST);
      end else if (CLK_EN) begin
         state_reg <= state_next;
      end
   end

   /*****************************************************************
    bus outputs
   *****************************************************************/
   // handshakes stall while the clock enable is low, so none is lost
   assign S_AXI_AWREADY = CLK_EN && !state_reg.aw_held && !state_reg.bvalid;
   assign S_AXI_WREADY = CLK_EN && !state_reg.w_held && !state_reg.bvalid;
   assign S_AXI_BVALID = CLK_EN && state_reg.bvalid;
   assign S_AXI_BRESP = state_reg.bresp;
   assign S_AXI_ARREADY = CLK_EN && !state_reg.rvalid;
   assign S_AXI_RVALID = CLK_EN && state_reg.rvalid;
   assign S_AXI_RRESP = state_reg.rresp;
   assign S_AXI_RDATA = state_reg.rdata;

   /*****************************************************************
    channel controls
   *****************************************************************/
   logic [CW-1:0] single_rail_eff;
   assign CLK_RECOVERY_ON = ~state_reg.clk_bypass;
   assign single_rail_eff =
      (state_reg.single_rail & ~state_reg.clk_bypass)
      | (~state_reg.single_rail & TX_NEGATIVE_RAIL_PIN);
   assign SINGLE_RAIL_MODE = single_rail_eff;
   assign AMI_SELECT = state_reg.line_code & single_rail_eff
      & ~state_reg.clk_bypass;
   assign RX_POWERDOWN = state_reg.rx_pdn;
   assign TX_POWERDOWN = state_reg.tx_pdn | ~TX_LINE_CLOCK_PIN;
   assign TX_HIGH_Z = TX_POWERDOWN;
   assign ZERO_RUN_DETECT_ON = state_reg.zero_run & single_rail_eff
      & ~AMI_SELECT;
   assign VIOLATION_DETECT_ON = ~state_reg.viol_dis & single_rail_eff
      & ~AMI_SELECT;
   assign RX_EQUALIZER_ON = state_reg.equalizer;
   assign EXPANDED_BANK =
      state_reg.bank_ptr == line_cfg_pkg::BANK_EXPANDED;
endmodule

/* logic/line_cfg_pkg.sv */
/*
 Constants for the four-channel line unit configuration register bank:
 register offsets, bank pointer codes, field layout and reset values.
 Assumes an AXI4-Lite slave with byte addresses four times the offset.
*/
package line_cfg_pkg;
   localparam int unsigned NUM_CH = 4;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   // expanded bank offsets
   localparam logic [7:0] OFS_SINGLE_RAIL = 8'h00;
   localparam logic [7:0] OFS_LINE_CODE = 8'h01;
   localparam logic [7:0] OFS_CLK_BYPASS = 8'h02;
   localparam logic [7:0] OFS_RX_PDN = 8'h03;
   localparam logic [7:0] OFS_TX_PDN = 8'h04;
   localparam logic [7:0] OFS_ZERO_RUN = 8'h05;
   localparam logic [7:0] OFS_VIOL_DIS = 8'h06;
   localparam logic [7:0] OFS_EQUALIZER = 8'h07;
   // primary bank offsets
   localparam logic [7:0] OFS_ALARM_MASK = 8'h14;
   localparam logic [7:0] OFS_ALARM_FLAGS = 8'h15;
   // both banks
   localparam logic [7:0] OFS_BANK_PTR = 8'h1f;
   // bank pointer codes, reset values, response codes and word address shift
   localparam logic [7:0] BANK_PRIMARY = 8'h00;
   localparam logic [7:0] BANK_EXPANDED = 8'haa;
   localparam logic [7:0] BANK_PTR_RST = 8'h00;
   localparam logic [3:0] CH_RST = 4'h0;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   localparam int unsigned WORD_LSB = 2;
endpackage

/* sim/line_cfg_regs_asserts.sv */
/*
 Concurrent checks on the line unit register bank ports.
 Assumes it is bound to line_cfg_regs and sees only its ports.
*/
`timescale 1ns/1ps
module line_cfg_regs_chk #(
   parameter int unsigned CHANNELS = 4
) (
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic CLK_EN,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic S_AXI_BVALID,
   input wire logic [CHANNELS-1:0] TX_NEGATIVE_RAIL_PIN,
   input wire logic [CHANNELS-1:0] TX_LINE_CLOCK_PIN,
   input wire logic [CHANNELS-1:0] SINGLE_RAIL_MODE,
   input wire logic [CHANNELS-1:0] AMI_SELECT,
   input wire logic [CHANNELS-1:0] CLK_RECOVERY_ON,
   input wire logic [CHANNELS-1:0] TX_POWERDOWN,
   input wire logic [CHANNELS-1:0] TX_HIGH_Z,
   input wire logic [CHANNELS-1:0] ZERO_RUN_DETECT_ON,
   input wire logic [CHANNELS-1:0] VIOLATION_DETECT_ON,
   input wire logic EXPANDED_BANK
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RST || !CLK_EN);
   // ****************************************
   // port relations
   // ****************************************
   AST_TX_CLK_LOW: assert property (
      (~TX_LINE_CLOCK_PIN & ~TX_POWERDOWN) == '0)
      else $error("tx clock low without powerdown");
   AST_TX_HIGH_Z: assert property (TX_HIGH_Z == TX_POWERDOWN)
      else $error("high-z differs from powerdown");
   AST_BYPASS_RAIL: assert property (
      (SINGLE_RAIL_MODE & ~CLK_RECOVERY_ON & ~TX_NEGATIVE_RAIL_PIN) == '0)
      else $error("bypass forced single");
   AST_AMI_GATE: assert property (
      (AMI_SELECT & ~(SINGLE_RAIL_MODE & CLK_RECOVERY_ON)) == '0)
      else $error("ami outside single rail");
   AST_ZERO_GATE: assert property (
      (ZERO_RUN_DETECT_ON & (~SINGLE_RAIL_MODE | AMI_SELECT)) == '0)
      else $error("zero run detect outside hdb3");
   AST_VIOL_GATE: assert property (
      (VIOLATION_DETECT_ON & (~SINGLE_RAIL_MODE | AMI_SELECT)) == '0)
      else $error("violation detect outside hdb3");
   AST_READ_ANSWER: assert property (
      S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read answer late");
   AST_RDATA_HOLD: assert property (
      S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read data dropped");
   AST_RDATA_UPPER: assert property (
      S_AXI_RVALID |-> S_AXI_RDATA[31:8] == '0)
      else $error("upper read bits set");
   AST_BANK_BY_WRITE: assert property (
      $changed(EXPANDED_BANK) |-> $rose(S_AXI_BVALID))
      else $error("bank moved without write");
   cover property (S_AXI_RVALID && !S_AXI_RREADY);
   cover property ($rose(EXPANDED_BANK));
   cover property (AMI_SELECT != '0);
endmodule
bind line_cfg_regs line_cfg_regs_chk #(.CHANNELS(CHANNELS)) chk (.SYS_CLK,
   .RST, .CLK_EN, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RVALID,
   .S_AXI_RREADY, .S_AXI_BVALID, .TX_NEGATIVE_RAIL_PIN, .TX_LINE_CLOCK_PIN,
   .SINGLE_RAIL_MODE, .AMI_SELECT, .CLK_RECOVERY_ON, .TX_POWERDOWN,
   .TX_HIGH_Z, .ZERO_RUN_DETECT_ON, .VIOLATION_DETECT_ON, .EXPANDED_BANK);

/* sim/line_cfg_regs_tb_top.sv */
/*
 Self-checking bench for the line unit register bank.
 Assumes the design answers the AXI4-Lite handshakes as handed over.
*/
`timescale 1ns/1ps
module line_cfg_regs_tb_top;
   typedef struct {logic [7:0] a; logic [31:0] d;} row_t;
   logic sys_clk, rst, awvalid, wvalid, bready, arvalid, rready, bank;
   logic awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   logic [3:0] alarm, neg, tclk, sr, ami, crec, rxp, txp, hiz, zr, vi, eq;
   int num_errors = 0;
   int compares = 0;
   row_t rows [8] = '{'{8'h00, 32'h3}, '{8'h04, 32'ha}, '{8'h08, 32'h5},
      '{8'h0c, 32'ha}, '{8'h10, 32'h1}, '{8'h14, 32'h6}, '{8'h18, 32'h2},
      '{8'h1c, 32'h6}};
   line_cfg_regs #(.CHANNELS(4)) uut (.SYS_CLK(sys_clk), .RST(rst),
      .CLK_EN(1'h1), .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0),
      .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .ALARM_STATUS(alarm),
      .TX_NEGATIVE_RAIL_PIN(neg), .TX_LINE_CLOCK_PIN(tclk),
      .SINGLE_RAIL_MODE(sr), .AMI_SELECT(ami), .CLK_RECOVERY_ON(crec),
      .RX_POWERDOWN(rxp), .TX_POWERDOWN(txp), .TX_HIGH_Z(hiz),
      .ZERO_RUN_DETECT_ON(zr), .VIOLATION_DETECT_ON(vi),
      .RX_EQUALIZER_ON(eq), .EXPANDED_BANK(bank));
   initial begin
      sys_clk = 1'h0;
      forever #25 sys_clk = ~sys_clk;
   end
   // ****************************************
   // compare and bus tasks
   // ****************************************
   task automatic chk_word(input string n, input logic [31:0] e,
      input logic [31:0] g);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic chk_resp(input string n, input logic [1:0] e,
      input logic [1:0] g);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic chk_pins(input string n, input logic [3:0] e,
      input logic [3:0] g);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
      logic aw_done, w_done;
      aw_done = 1'h0;
      w_done = 1'h0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      while (!(aw_done && w_done)) begin
         @(posedge sys_clk);
         if (awready === 1'h1) aw_done = 1'h1;
         if (wready === 1'h1) w_done = 1'h1;
         if (aw_done) awvalid <= 1'h0;
         if (w_done) wvalid <= 1'h0;
      end
      do @(posedge sys_clk); while (bvalid !== 1'h1);
      chk_resp("write resp", er, bresp);
      bready <= 1'h0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] er, input int dly = 0);
      araddr <= a;
      arvalid <= 1'h1;
      do @(posedge sys_clk); while (arready !== 1'h1);
      arvalid <= 1'h0;
      repeat (dly) @(posedge sys_clk);
      rready <= 1'h1;
      do @(posedge sys_clk); while (rvalid !== 1'h1);
      chk_word("read data", e, rdata);
      chk_resp("read resp", er, rresp);
      rready <= 1'h0;
      @(posedge sys_clk);
   endtask
   task automatic tally_and_finish;
      $display("compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge sys_clk);
      num_errors++;
      tally_and_finish;
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
      {awaddr, araddr, wdata} = 48'h0;
      {alarm, neg, tclk} = 12'h0cb;
      repeat (2) @(posedge sys_clk);
      rst <= 1'h0;
      chk_pins("bank", 4'h0, {3'h0, bank});
      rd(8'h7c, 32'h0, 2'h0);
      rd(8'h00, 32'h0, 2'h2);
      wr(8'h7c, 32'haa, 2'h0);
      chk_pins("bank", 4'h1, {3'h0, bank});
      rd(8'h54, 32'h0, 2'h2);
      for (int i = 0; i < 8; i++) begin
         rd(rows[i].a, 32'h0, 2'h0);
         wr(rows[i].a, rows[i].d, 2'h0);
         rd(rows[i].a, rows[i].d, 2'h0);
      end
      $display("register rows done");
      chk_pins("single rail", 4'he, sr);
      chk_pins("ami", 4'ha, ami);
      chk_pins("recovery", 4'ha, crec);
      chk_pins("rx powerdown", 4'ha, rxp);
      chk_pins("tx high z", 4'h5, hiz);
      chk_pins("tx powerdown", 4'h5, txp);
      chk_pins("zero run", 4'h4, zr);
      chk_pins("violation", 4'h4, vi);
      chk_pins("equalizer", 4'h6, eq);
      neg <= 4'h0;
      tclk <= 4'hf;
      @(posedge sys_clk);
      chk_pins("single rail", 4'h2, sr);
      chk_pins("tx powerdown", 4'h1, txp);
      $display("channel controls done");
      wr(8'h7c, 32'h55, 2'h0);
      rd(8'h00, 32'h0, 2'h2);
      rd(8'h7c, 32'h55, 2'h0);
      wr(8'h7c, 32'h0, 2'h0);
      wr(8'h50, 32'h5, 2'h0);
      rd(8'h50, 32'h5, 2'h0, 3);
      alarm <= 4'hf;
      repeat (2) @(posedge sys_clk);
      rd(8'h54, 32'h5, 2'h0);
      rd(8'h54, 32'h0, 2'h0);
      alarm <= 4'h0;
      repeat (2) @(posedge sys_clk);
      rd(8'h54, 32'h5, 2'h0);
      wr(8'h54, 32'hf, 2'h0);
      rd(8'h54, 32'h0, 2'h0);
      rd(8'h20, 32'h0, 2'h2);
      rd(8'h51, 32'h0, 2'h2);
      wr(8'h20, 32'h1, 2'h2);
      $display("alarm and map done");
      wr(8'h7c, 32'haa, 2'h0);
      rst <= 1'h1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'h0;
      chk_pins("bank", 4'h0, {3'h0, bank});
      rd(8'h7c, 32'h0, 2'h0);
      $display("second reset done");
      tally_and_finish;
   end
endmodule
